// *** bench/imc_app.sv ***
// Behavioural application that requests and feeds transmit messages.
// Assumes the channel top on the same clock and one message at a time.
`default_nettype none

module imc_app
(
  // Clock, reset and control from the bench
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [7:0] code,
  input wire logic stall,
  output logic busy,
  // Message port towards the channel
  output imc_pkg::imc_msg_req_t tx_msg_req,
  output logic [63:0] tx_msg_tdata,
  output logic tx_msg_tvalid,
  input wire logic tx_msg_tready
);
  timeunit 1ns;
  timeprecision 1ns;
  import imc_pkg::*;

  int left = 0;

  // Quiet outputs before the first edge.
  initial
  begin
    tx_msg_req = '0;
    tx_msg_tvalid = 1'b0;
    tx_msg_tdata = '0;
  end

  // Bytes owed count down per word taken; a refused word stays put, and idle data churns
  // every cycle so that a stale value can never pass for a fresh one.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      left = 0;
    else if (tx_msg_tvalid && tx_msg_tready)
      left = left - IMC_LANE_BYTES;
    if (go && rst_n)
      left = int'(code) + 1;
    tx_msg_req <= '{go && rst_n, code};
    if (!tx_msg_tvalid || tx_msg_tready)
    begin
      tx_msg_tvalid <= left > 0 && !(stall && $urandom_range(1) == 0);
      tx_msg_tdata <= {$urandom, $urandom};
    end
  end

  // The bench waits on this before asking again.
  assign busy = left > 0;
endmodule

`default_nettype wire

// *** bench/imc_chk.sv ***
// Port checker for the message channel top.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none

module imc_chk
#(
  parameter int LANES = 1
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Transmit side
  input wire imc_pkg::imc_msg_req_t tx_msg_req,
  input wire logic tx_msg_tvalid,
  input wire logic tx_msg_tready,
  input wire logic tx_frame_tready,
  input wire imc_pkg::imc_hp_t hp_busy,
  input wire imc_pkg::imc_link_t link_tx_ctl,
  // Receive side
  input wire imc_pkg::imc_link_t link_rx_ctl,
  input wire logic [LANES*64-1:0] link_rx_data,
  input wire logic [LANES*64-1:0] rx_msg_tdata,
  input wire logic rx_msg_tvalid,
  input wire logic rx_msg_tlast,
  input wire logic [LANES*8-1:0] rx_msg_tkeep,
  input wire logic rx_msg_busy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  import imc_pkg::*;

  // A message word arriving from the link.
  wire logic msg_in = link_rx_ctl.valid && link_rx_ctl.kind == IMC_LK_MSG;

  default clocking ck @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ********
  // Transmit
  // ********
  a_ready_excl: assert property (tx_msg_tready |-> !tx_frame_tready)
    else $error("message and frame ready both high");
  a_ready_delay: assert property (tx_msg_req.req && !tx_msg_tready && hp_busy == '0
    ##1 hp_busy == '0 |-> !tx_msg_tready && !tx_frame_tready ##1 tx_msg_tready)
    else $error("message ready not two cycles after request");
  a_prio_drop: assert property (|hp_busy |=> !tx_msg_tready && !tx_frame_tready)
    else $error("ready high while a priority block owns the lane");
  a_idle_fill: assert property (tx_msg_tready && !tx_msg_tvalid && hp_busy == '0
    |=> tx_msg_tready && link_tx_ctl.valid && link_tx_ctl.kind == IMC_LK_IDLE)
    else $error("no idle block for a message gap");
  a_msg_fwd: assert property (tx_msg_tvalid && tx_msg_tready && hp_busy == '0
    |=> link_tx_ctl.valid && link_tx_ctl.kind == IMC_LK_MSG)
    else $error("accepted message word not sent");

  // *******
  // Receive
  // *******
  a_rx_word: assert property (msg_in && !rx_msg_busy_n
    |=> rx_msg_tvalid && rx_msg_tdata == $past(link_rx_data))
    else $error("received word not presented");
  a_rx_quiet: assert property (!msg_in |=> !rx_msg_tvalid)
    else $error("valid without a message word");
  a_keep_full: assert property (rx_msg_tvalid && !rx_msg_tlast |-> &rx_msg_tkeep)
    else $error("keep not full on an inner word");
  a_keep_contig: assert property (rx_msg_tlast |-> rx_msg_tkeep != '0
    && ((~rx_msg_tkeep) & ((~rx_msg_tkeep) + 1'b1)) == '0)
    else $error("keep not contiguous from the top byte");
  a_busy_level: assert property (rx_msg_tvalid |-> rx_msg_busy_n == rx_msg_tlast)
    else $error("reception status wrong");
endmodule

bind imc_channel imc_chk #(.LANES(LANES)) chk_u (.sys_clk, .rst_n, .tx_msg_req,
  .tx_msg_tvalid, .tx_msg_tready, .tx_frame_tready, .hp_busy, .link_tx_ctl, .link_rx_ctl,
  .link_rx_data, .rx_msg_tdata, .rx_msg_tvalid, .rx_msg_tlast, .rx_msg_tkeep, .rx_msg_busy_n);

`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench of the message channel with one lane.
// Assumes the package, design, checker and application model are compiled first.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import imc_pkg::*;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic stall = 1'b0;
  logic app_busy;
  logic [7:0] code = 8'h00;
  logic [7:0] rx_msg_tkeep, kexp;
  logic [63:0] tx_msg_tdata, link_tx_data, rx_msg_tdata;
  logic [63:0] tx_frame_tdata = 64'h0, link_rx_data = 64'h0;
  logic tx_msg_tvalid, tx_msg_tready, tx_frame_tready, rx_msg_tvalid, rx_msg_tlast;
  logic rx_msg_busy_n;
  logic tx_frame_tvalid = 1'b0, frame_path_ready = 1'b0;
  imc_msg_req_t tx_msg_req;
  imc_hp_t hp_busy = '0;
  imc_link_t link_tx_ctl, link_rx_ctl = '0;
  int err_total = 0, checks_done = 0, rem = 0;
  int codes[6] = '{0, 3, 7, 8, 15, 255};
  int nq[$];
  logic [63:0] hq[$], mq[$], fq[$], rq[$];

  imc_channel #(.LANES(1)) dut_u (.sys_clk, .rst_n, .tx_msg_req, .tx_msg_tdata, .tx_msg_tvalid,
    .tx_msg_tready, .tx_frame_tdata, .tx_frame_tvalid, .tx_frame_tready, .frame_path_ready,
    .hp_busy, .link_tx_ctl, .link_tx_data, .link_rx_ctl, .link_rx_data, .rx_msg_tdata,
    .rx_msg_tvalid, .rx_msg_tlast, .rx_msg_tkeep, .rx_msg_busy_n);
  imc_app app_u (.sys_clk, .rst_n, .go, .code, .stall, .busy(app_busy), .tx_msg_req,
    .tx_msg_tdata, .tx_msg_tvalid, .tx_msg_tready);

  // The clock toggles every half period of 25 ns.
  always #25 sys_clk = ~sys_clk;

  // *******
  // Helpers
  // *******
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask

  // Mask of the n leftmost bytes, the only ones a short last word carries.
  function automatic logic [63:0] top(int n);
    return ~({64{1'b1}} >> (8 * (n > 8 ? 8 : n)));
  endfunction

  task automatic print_verdict();
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tx_msg(int c, bit s);
    code <= 8'(c);
    stall <= s;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    for (int k = 0; k < 3000 && app_busy; k++)
      @(posedge sys_clk);
    chk("tx_done", 64'h0, 64'(app_busy));
  endtask

  // Header then words, with idle gaps thrown in at random.
  task automatic rx_msg(int c);
    int r;
    logic [63:0] w;
    bit gap;
    r = c + 1;
    link_rx_ctl <= '{1'b1, IMC_LK_HDR};
    link_rx_data <= 64'(c);
    @(posedge sys_clk);
    while (r > 0)
    begin
      w = {$urandom, $urandom};
      gap = $urandom_range(3) == 0;
      link_rx_ctl <= '{1'b1, gap ? IMC_LK_IDLE : IMC_LK_MSG};
      link_rx_data <= w;
      if (!gap)
      begin
        rq.push_back(w);
        nq.push_back(r);
        r -= 8;
      end
      @(posedge sys_clk);
    end
  endtask

  // Frame traffic, lane owners and downstream backpressure run freely around messages.
  always @(posedge sys_clk)
  begin
    if (!tx_frame_tvalid || tx_frame_tready)
    begin
      tx_frame_tvalid <= $urandom_range(1);
      tx_frame_tdata <= {$urandom, $urandom};
    end
    hp_busy <= $urandom_range(11) == 0 ? 4'h1 << $urandom_range(3) : 4'h0;
    frame_path_ready <= $urandom_range(3) != 0;
  end

  // Reference model: each accepted unit becomes an expected block of its own kind.
  always @(posedge sys_clk)
  begin
    if (rst_n)
    begin
      if (tx_msg_tvalid && tx_msg_tready)
      begin
        mq.push_back(tx_msg_tdata & top(rem));
        rem -= 8;
      end
      if (tx_msg_req.req)
      begin
        rem = tx_msg_req.msg_size_code + 1;
        hq.push_back(64'(tx_msg_req.msg_size_code));
      end
      if (tx_frame_tvalid && tx_frame_tready)
        fq.push_back(tx_frame_tdata);
      if (link_tx_ctl.valid && link_tx_ctl.kind == IMC_LK_HDR)
        chk("header", hq.pop_front(), link_tx_data);
      if (link_tx_ctl.valid && link_tx_ctl.kind == IMC_LK_MSG)
        chk("msg_word", mq.pop_front(), link_tx_data);
      if (link_tx_ctl.valid && link_tx_ctl.kind == IMC_LK_FRAME)
        chk("frame_word", fq.pop_front(), link_tx_data);
      if (rx_msg_tvalid)
        chk("rx_expected", 64'h1, 64'(rq.size() > 0));
      if (rx_msg_tvalid && rq.size() > 0)
      begin
        kexp = 8'hff << (8 - (nq[0] > 8 ? 8 : nq[0]));
        chk("rx_data", rq[0] & top(nq[0]), rx_msg_tdata & top(nq[0]));
        chk("rx_keep", {56'h0, kexp}, {56'h0, rx_msg_tkeep});
        chk("rx_last", 64'(nq[0] < 9), 64'(rx_msg_tlast));
        chk("rx_busy_n", 64'(nq[0] < 9), 64'(rx_msg_busy_n));
        void'(rq.pop_front());
        void'(nq.pop_front());
      end
    end
  end

  // Main sequence: both directions at once, then a stray word with no header.
  initial
  begin
    void'($urandom(12384));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    fork
      for (int i = 0; i < 16; i++)
        tx_msg(i < 6 ? codes[i] : $urandom_range(255), i[0]);
      for (int i = 0; i < 16; i++)
        rx_msg(i < 6 ? codes[i] : $urandom_range(255));
    join
    link_rx_ctl <= '{1'b1, IMC_LK_MSG};
    @(posedge sys_clk);
    link_rx_ctl <= '0;
    repeat (20) @(posedge sys_clk);
    chk("left_over", 64'h0, 64'(hq.size() + mq.size() + rq.size()));
    print_verdict();
  end

  // A hang is cut short far beyond the few hundred cycles the run needs.
  initial
  begin
    #2ms;
    err_total++;
    print_verdict();
  end
endmodule

`default_nettype wire

// *** rtl/imc_channel.sv ***
// Top of the in-band user message channel: transmit framing and receive.
// Assumes the frame path, the priority sources and the lane encoder all run
// on sys_clk, so none of their signals need synchronising.
`default_nettype none

// Notes on behaviour
// (R1) Messages pre-empt frame data mid-frame.
// (R2) Priority blocks pause a message, then it resumes.
// (R3) Application pulses request one cycle with size.
// (R4) Size code is bytes minus one, max 256.
// (R5) Message ready rises two cycles after request.
// (R6) Message ready stays high until message complete.
// (R7) Frame ready low whenever message ready high.
// (R8) Message ready drops during priority operations.
// (R9) Valid low inside message sends idles.
// (R10) No new request before final data cycle.
// (R11) Message data captured only on valid and ready.
// (R12) Last word uses only needed leftmost bytes.
// (R13) Both readies low one cycle for header.
// (R14) Receive data has valid and last outputs.
// (R15) Receive keep meaningful only on last word.
// (R16) Keep bits contiguous from most significant byte.
// (R17) Active-low receive status during reception.
// (R18) Bus numbering ascending by default, descending optionally; buses here are declared descending only, with no option.
module imc_channel
#(
  parameter int LANES = imc_pkg::IMC_LANES_DEF
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Message request and message data from the application
  input wire imc_pkg::imc_msg_req_t tx_msg_req,
  input wire logic [LANES*64-1:0] tx_msg_tdata,
  input wire logic tx_msg_tvalid,
  output logic tx_msg_tready,
  // Regular frame data path
  input wire logic [LANES*64-1:0] tx_frame_tdata,
  input wire logic tx_frame_tvalid,
  output logic tx_frame_tready,
  input wire logic frame_path_ready,
  // Higher-priority block sources
  input wire imc_pkg::imc_hp_t hp_busy,
  // Blocks towards the lane encoder
  output imc_pkg::imc_link_t link_tx_ctl,
  output logic [LANES*64-1:0] link_tx_data,
  // Decoded blocks from the lane decoder
  input wire imc_pkg::imc_link_t link_rx_ctl,
  input wire logic [LANES*64-1:0] link_rx_data,
  // Received message stream
  output logic [LANES*64-1:0] rx_msg_tdata,
  output logic rx_msg_tvalid,
  output logic rx_msg_tlast,
  output logic [LANES*8-1:0] rx_msg_tkeep,
  output logic rx_msg_busy_n
);
  import imc_pkg::*;

  // ****************************************************************
  // Parameters and checks
  // ****************************************************************
  localparam int BYTES = LANES * IMC_LANE_BYTES;
  localparam int DW = LANES * 64;
  localparam logic [IMC_CNT_W-1:0] BYTES_C = IMC_CNT_W'(BYTES);

  if (LANES < 1 || LANES > IMC_LANES_MAX)
  begin : g_lane_check
    $error("LANES must lie between 1 and 32.");
  end

  typedef enum logic [1:0] {
    IMC_ST_IDLE = 2'b00,
    IMC_ST_HDR = 2'b01,
    IMC_ST_DATA = 2'b10
  } imc_state_t;

  imc_state_t state_r;
  imc_state_t state_nxt;
  logic [IMC_CNT_W-1:0] left_r;
  logic [IMC_SIZE_W-1:0] size_r;
  logic hp_any;
  logic msg_accept;
  logic frame_accept;
  logic last_beat;
  logic [BYTES-1:0] byte_keep;
  logic [DW-1:0] data_mask;
  logic [IMC_MAX_KEEP-1:0] top_keep;

  // ****************************************************************
  // Transmit sequencing
  // ****************************************************************
  // Any running higher-priority source holds the message off.
  assign hp_any = |hp_busy; // [R2] [R8]
  assign msg_accept = tx_msg_tvalid && tx_msg_tready; // [R11]
  assign frame_accept = tx_frame_tvalid && tx_frame_tready;
  assign last_beat = left_r <= BYTES_C;

  // Next state; a request in the final data cycle chains straight on.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      IMC_ST_IDLE:
      begin
        if (tx_msg_req.req)
          state_nxt = IMC_ST_HDR; // [R1]
      end
      IMC_ST_HDR:
      begin
        // The header slot waits while priority blocks own the lane.
        if (!hp_any)
          state_nxt = IMC_ST_DATA; // [R13] [R2]
      end
      IMC_ST_DATA:
      begin
        if (msg_accept && last_beat)
          state_nxt = tx_msg_req.req ? IMC_ST_HDR : IMC_ST_IDLE; // [R10]
      end
      default:
        state_nxt = IMC_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      state_r <= IMC_ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Bytes still owed; a request loads size code plus one.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      left_r <= '0;
      size_r <= '0;
    end
    else if (tx_msg_req.req && (state_r == IMC_ST_IDLE || (msg_accept && last_beat)))
    begin
      left_r <= IMC_CNT_W'(tx_msg_req.msg_size_code) + IMC_CNT_W'(1); // [R3] [R4]
      size_r <= tx_msg_req.msg_size_code;
    end
    else if (msg_accept)
      left_r <= last_beat ? '0 : left_r - BYTES_C;
  end

  // ****************************************************************
  // Ready outputs
  // ****************************************************************
  // Both readies are registered, so a priority source that starts now
  // removes them one cycle later; the word accepted in that cycle still
  // goes out, which keeps data from being lost at the cost of that lag.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      tx_msg_tready <= 1'b0;
      tx_frame_tready <= 1'b0;
    end
    else
    begin
      // Low in the header cycle, high from the second cycle after the request.
      tx_msg_tready <= state_nxt == IMC_ST_DATA && !hp_any; // [R5] [R6] [R8] [R13]
      // Frame data only flows when no message is pending at all.
      tx_frame_tready <= state_nxt == IMC_ST_IDLE && !hp_any && frame_path_ready; // [R7] [R1]
    end
  end

  // ****************************************************************
  // Last-word byte masking
  // ****************************************************************
  // The leftmost byte is the most significant bit group of the vector; the
  // ascending and descending numberings name the same wires, so only the
  // labels differ between the two bus conventions. [R18]
  assign top_keep = imc_top_mask(BYTES, left_r);
  assign byte_keep = last_beat ? top_keep[BYTES-1:0] : '1; // [R12]

  for (genvar b = 0; b < BYTES; b++)
  begin : g_mask
    assign data_mask[b*8 +: 8] = {8{byte_keep[b]}};
  end

  // ****************************************************************
  // Block output towards the lane encoder
  // ****************************************************************
  // An accepted word always leaves; otherwise priority sources own the lane.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      link_tx_ctl <= '{valid: 1'b0, kind: IMC_LK_NONE};
      link_tx_data <= '0;
    end
    else if (msg_accept)
    begin
      link_tx_ctl <= '{valid: 1'b1, kind: IMC_LK_MSG}; // [R11]
      link_tx_data <= tx_msg_tdata & data_mask; // [R12]
    end
    else if (frame_accept)
    begin
      link_tx_ctl <= '{valid: 1'b1, kind: IMC_LK_FRAME};
      link_tx_data <= tx_frame_tdata;
    end
    else if (hp_any)
    begin
      link_tx_ctl <= '{valid: 1'b0, kind: IMC_LK_NONE}; // [R2]
      link_tx_data <= '0;
    end
    else if (state_r == IMC_ST_HDR)
    begin
      link_tx_ctl <= '{valid: 1'b1, kind: IMC_LK_HDR}; // [R13]
      link_tx_data <= DW'(size_r); // [R4]
    end
    else if (tx_msg_tready)
    begin
      // Stalled application inside a message: fill with idles.
      link_tx_ctl <= '{valid: 1'b1, kind: IMC_LK_IDLE}; // [R9]
      link_tx_data <= '0;
    end
    else
    begin
      link_tx_ctl <= '{valid: 1'b0, kind: IMC_LK_NONE};
      link_tx_data <= '0;
    end
  end

  // ****************************************************************
  // Receive side
  // ****************************************************************
  imc_rx #(
    .LANES(LANES)
  ) u_rx (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .link_rx_ctl(link_rx_ctl),
    .link_rx_data(link_rx_data),
    .rx_msg_tdata(rx_msg_tdata),
    .rx_msg_tvalid(rx_msg_tvalid),
    .rx_msg_tlast(rx_msg_tlast),
    .rx_msg_tkeep(rx_msg_tkeep),
    .rx_msg_busy_n(rx_msg_busy_n)
  );

endmodule

`default_nettype wire

// *** rtl/imc_pkg.sv ***
// Shared types and constants of the in-band user message channel.
// Assumes a single user clock and a link layer that carries typed blocks.
`default_nettype none

package imc_pkg;

  // ****************************************************************
  // Sizes and counts
  // ****************************************************************
  localparam int IMC_LANE_BYTES = 8;
  localparam int IMC_LANES_DEF = 1;
  localparam int IMC_LANES_MAX = 32;
  localparam int IMC_MAX_KEEP = IMC_LANES_MAX * IMC_LANE_BYTES;
  localparam int IMC_MAX_MSG_BYTES = 256;
  localparam int IMC_SIZE_W = 8;
  localparam int IMC_CNT_W = 9;

  // ****************************************************************
  // Types
  // ****************************************************************
  // Kind of block handed to, or taken from, the lane encoder.
  typedef enum logic [2:0] {
    IMC_LK_NONE = 3'b000,
    IMC_LK_IDLE = 3'b001,
    IMC_LK_HDR = 3'b010,
    IMC_LK_MSG = 3'b011,
    IMC_LK_FRAME = 3'b100
  } imc_kind_t;

  typedef struct packed {
    logic valid;
    imc_kind_t kind;
  } imc_link_t;

  typedef struct packed {
    logic req;
    logic [IMC_SIZE_W-1:0] msg_size_code;
  } imc_msg_req_t;

  // Busy levels of the higher-priority block sources.
  typedef struct packed {
    logic clock_compensation_block;
    logic channel_bonding_block;
    logic not_ready_idle_block;
    logic native_flow_block;
  } imc_hp_t;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Byte mask with the n most significant of width bytes set.
  function automatic logic [IMC_MAX_KEEP-1:0] imc_top_mask(input int width,
                                                           input logic [IMC_CNT_W-1:0] n);
    logic [IMC_MAX_KEEP-1:0] m;
    m = '0;
    for (int i = 0; i < IMC_MAX_KEEP; i++)
    begin
      if (i < width && i >= width - int'(n))
        m[i] = 1'b1;
    end
    return m;
  endfunction

endpackage

`default_nettype wire

// *** rtl/imc_rx.sv ***
// Receive side of the in-band user message channel.
// Assumes link blocks arrive already decoded, on the same clock.
`default_nettype none

module imc_rx
#(
  parameter int LANES = imc_pkg::IMC_LANES_DEF
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Decoded link blocks
  input wire imc_pkg::imc_link_t link_rx_ctl,
  input wire logic [LANES*64-1:0] link_rx_data,
  // Received message stream
  output logic [LANES*64-1:0] rx_msg_tdata,
  output logic rx_msg_tvalid,
  output logic rx_msg_tlast,
  output logic [LANES*8-1:0] rx_msg_tkeep,
  output logic rx_msg_busy_n
);
  import imc_pkg::*;

  localparam int BYTES = LANES * IMC_LANE_BYTES;
  localparam logic [IMC_CNT_W-1:0] BYTES_C = IMC_CNT_W'(BYTES);

  logic [IMC_CNT_W-1:0] left_r;
  logic hdr_seen;
  logic msg_seen;
  logic last_word;
  logic [IMC_MAX_KEEP-1:0] top_keep;

  // ****************************************************************
  // Block decode
  // ****************************************************************
  // Message words only count after a header, so stray words are dropped.
  assign hdr_seen = link_rx_ctl.valid && link_rx_ctl.kind == IMC_LK_HDR;
  assign msg_seen = link_rx_ctl.valid && link_rx_ctl.kind == IMC_LK_MSG && !rx_msg_busy_n;
  assign last_word = left_r <= BYTES_C;
  assign top_keep = imc_top_mask(BYTES, left_r);

  // Remaining byte count and the active-low reception status.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      left_r <= '0;
      rx_msg_busy_n <= 1'b1;
    end
    else if (hdr_seen)
    begin
      left_r <= IMC_CNT_W'(link_rx_data[IMC_SIZE_W-1:0]) + IMC_CNT_W'(1);
      rx_msg_busy_n <= 1'b0; // [R17]
    end
    else if (msg_seen)
    begin
      left_r <= last_word ? '0 : left_r - BYTES_C;
      rx_msg_busy_n <= last_word; // [R17]
    end
  end

  // Output word, valid, last and keep; idles inside a message show as gaps.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rx_msg_tdata <= '0;
      rx_msg_tvalid <= 1'b0;
      rx_msg_tlast <= 1'b0;
      rx_msg_tkeep <= '0;
    end
    else
    begin
      rx_msg_tvalid <= msg_seen; // [R14]
      rx_msg_tlast <= msg_seen && last_word; // [R14]
      if (msg_seen)
      begin
        rx_msg_tdata <= link_rx_data;
        // Keep fills from the top byte down; full words keep every byte.
        rx_msg_tkeep <= last_word ? top_keep[BYTES-1:0] : '1; // [R15] [R16]
      end
    end
  end

endmodule

`default_nettype wire
